// [hw/squib_diag_cfg.svh]
// Purpose: Constants of the diagnostic-mode command decoder
// Assumes: Included by the frame port and decoder design modules
// Notes:   Definitions only

`ifndef SQUIB_DIAG_CFG_SVH
`define SQUIB_DIAG_CFG_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define DIAG_MODE_CODE 2'h2
`define FRAME_BITS 5'h10
`define COUNT_MAX 5'h1f
`define CHANNELS 8

// ----------------------------------------
// Reset and idle values
// ----------------------------------------
`define SETUP_RESET 13'h0000
`define RESP_IDLE 16'h0000
`define CS_IDLE 2'h3
`define MONITOR_RESET 8'h01

`endif

// [hw/squib_diag_pkg.sv]
// Purpose: Types of the diagnostic-mode command decoder
// Assumes: Field order follows the 16-bit command and response words
// Notes:   Constants live in squib_diag_cfg.svh

package squib_diag_pkg;

  // Diagnostic settings, command bits 12 down to 0
  typedef struct packed {
    logic write;
    logic switch_en;
    logic switch_high;
    logic current_en;
    logic measure_sel;
    logic analog_output_pin_en;
    logic [2:0] monitor_ch;
    logic calibrate;
    logic [2:0] current_ch;
  } setup_type;

  typedef struct packed {
    logic [1:0] mode;
    logic parity;
    setup_type setup;
  } command_type;

  typedef struct packed {
    logic [1:0] mode;
    logic battery_short;
    logic switch_fault;
    logic [3:0] setup_echo;
    logic ground_below;
    logic [2:0] monitor_ch;
    logic overcurrent;
    logic [2:0] current_ch;
  } response_type;

  // Per-channel comparator levels
  typedef struct packed {
    logic [7:0] ground_below;
    logic [7:0] battery_short;
    logic [7:0] overcurrent;
    logic [7:0] switch_fault;
  } compare_type;

  // Per-channel analog controls
  typedef struct packed {
    logic [7:0] bias;
    logic [7:0] source;
    logic [7:0] sink;
    logic [7:0] low_side;
    logic [7:0] high_side;
    logic [7:0] monitor;
    logic analog_output_pin_oe;
    logic calibrate;
  } drive_type;

  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] mosi_s;
    logic sclk_prev;
    logic cs_prev;
    logic [4:0] count;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic miso;
    logic start;
    logic done;
    logic [15:0] word;
  } port_state_type;

  typedef struct packed {
    setup_type setup;
    logic pending;
    compare_type cmp_meta;
    compare_type cmp_sync;
    drive_type drive;
  } core_state_type;

endpackage : squib_diag_pkg

// [hw/frame_port.sv]
// Purpose: Serial link slave, 16-bit frames, clock low at idle
// Assumes: Link clock much slower than clk; pins sampled by two flops
// Notes:   Data taken on link clock rise, shifted out on its fall

`timescale 1ns/1ps
`include "squib_diag_cfg.svh"

module frame_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // Word side
  input wire logic [15:0] tx_word,
  output logic frame_start,
  output logic frame_done,
  output logic [15:0] rx_word
);

  squib_diag_pkg::port_state_type st_reg;
  squib_diag_pkg::port_state_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.sclk_s = {st_reg.sclk_s[0], sclk};
    st_next.cs_s = {st_reg.cs_s[0], cs_n};
    st_next.mosi_s = {st_reg.mosi_s[0], mosi};
    st_next.sclk_prev = st_reg.sclk_s[1];
    st_next.cs_prev = st_reg.cs_s[1];
    st_next.start = 1'b0;
    st_next.done = 1'b0;
    if (st_reg.cs_prev && !st_reg.cs_s[1]) begin
      // Frame opens: reply is loaded here
      st_next.start = 1'b1;
      st_next.count = 5'h00;
      st_next.shift_out = tx_word;
      st_next.miso = tx_word[15];
    end else if (!st_reg.cs_prev && st_reg.cs_s[1]) begin
      // Only whole 16-bit frames count
      if (st_reg.count == `FRAME_BITS) begin
        st_next.done = 1'b1;
        st_next.word = st_reg.shift_in;
      end
    end else if (!st_reg.cs_s[1]) begin
      if (!st_reg.sclk_prev && st_reg.sclk_s[1]) begin
        st_next.shift_in = {st_reg.shift_in[14:0], st_reg.mosi_s[1]};
        if (st_reg.count != `COUNT_MAX) begin
          st_next.count = st_reg.count + 5'h01;
        end
      end
      if (st_reg.sclk_prev && !st_reg.sclk_s[1]) begin
        st_next.shift_out = {st_reg.shift_out[14:0], 1'b0};
        st_next.miso = st_reg.shift_out[14];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.cs_s <= `CS_IDLE;
      st_reg.cs_prev <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign miso = st_reg.miso;
  assign frame_start = st_reg.start;
  assign frame_done = st_reg.done;
  assign rx_word = st_reg.word;

endmodule : frame_port

// [hw/squib_diagnostic_mode_decoder.sv]
// Purpose: Diagnostic-mode command decoder of an eight-channel squib driver
// Assumes: Host is link master; comparator levels are asynchronous
// Notes:   Other frame modes are decoded elsewhere; here they reply zero
//
// Behaviour
// - Top bits 1 then 0 mark a diagnostic frame; other codes are other modes.
// - Reply to a command goes out in the next valid selected frame.
// - Bit 13 makes the whole sixteen-bit word odd parity; device checks it.
// - Settings in bits 12..0 apply only when bit 12 is one.
// - Every diagnostic frame, read or write, gets a diagnostic reply next.
// - Measure source and sink on only when bits 8,9,12 set, 11 clear.
// - Bit 11 enables switch test; bit 10 picks low (0) or high (1).
// - Bit 11 clear disables switch test and bit 10 does nothing.
// - Bit 9 enables a current; bit 8 picks bias (0) or measure (1).
// - Bit 9 clear turns every diagnostic current off, bit 8 ignored.
// - Bits 2..0 pick the one current channel in plain binary.
// - Bits 6..4 pick the monitored channel for output and all comparators but switch fault.
// - Monitor channel field resets to zero, channel 0.
// - Current and monitor selects are independent and each one channel at most.
// - Bit 7 drives the analog output; clear means high impedance.
// - Bit 3 selects calibration voltage, else measure result; resets to zero.
// - Comparator results are captured into the reply status bits.
// - Reply bit 7 is one when monitored low pin is below ground threshold.
// - Reply bit 13 flags battery short, bit 3 overcurrent; zero when healthy.
// - Write bit, switch, current and output enables reset to zero.

`timescale 1ns/1ps
`include "squib_diag_cfg.svh"

module squib_diagnostic_mode_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Link pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // Comparator levels per channel
  input wire logic [7:0] ground_below,
  input wire logic [7:0] battery_short,
  input wire logic [7:0] overcurrent,
  input wire logic [7:0] switch_fault,
  // Current source controls per channel
  output logic [7:0] bias_current_en,
  output logic [7:0] measure_source_en,
  output logic [7:0] measure_sink_en,
  // Switch test controls per channel
  output logic [7:0] low_side_test_en,
  output logic [7:0] high_side_test_en,
  // Monitor and analog output
  output logic [7:0] monitor_select,
  output logic analog_output_oe,
  output logic analog_output_calibrate
);

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  squib_diag_pkg::core_state_type st_reg;
  squib_diag_pkg::core_state_type st_next;
  squib_diag_pkg::compare_type cmp_in;
  squib_diag_pkg::response_type rsp;
  wire squib_diag_pkg::drive_type drv;
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic frame_start;
  logic frame_done;
  logic is_diag;
  logic parity_ok;

  // ----------------------------------------
  // Link slave
  // ----------------------------------------
  frame_port port (
    .clk(clk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .tx_word(tx_word),
    .frame_start(frame_start),
    .frame_done(frame_done),
    .rx_word(rx_word)
  );

  // ----------------------------------------
  // Frame decode
  // ----------------------------------------
  assign is_diag = rx_word[15:14] == `DIAG_MODE_CODE;
  assign parity_ok = ^rx_word;

  assign cmp_in = '{
    ground_below: ground_below,
    battery_short: battery_short,
    overcurrent: overcurrent,
    switch_fault: switch_fault
  };

  // ----------------------------------------
  // Reply word
  // ----------------------------------------
  // Comparators read after two sync flops at frame open; switch fault for the current channel, the others for the monitored one
  assign rsp = '{
    mode: `DIAG_MODE_CODE,
    battery_short: st_reg.cmp_sync.battery_short[st_reg.setup.monitor_ch],
    switch_fault: st_reg.cmp_sync.switch_fault[st_reg.setup.current_ch],
    setup_echo: {st_reg.setup.switch_en, st_reg.setup.switch_high,
                 st_reg.setup.current_en, st_reg.setup.measure_sel},
    ground_below: st_reg.cmp_sync.ground_below[st_reg.setup.monitor_ch],
    monitor_ch: st_reg.setup.monitor_ch,
    overcurrent: st_reg.cmp_sync.overcurrent[st_reg.setup.monitor_ch],
    current_ch: st_reg.setup.current_ch
  };

  // Previous frame decides the reply of this one
  assign tx_word = st_reg.pending ? 16'(rsp) : `RESP_IDLE;

  // ----------------------------------------
  // Per-channel decode
  // ----------------------------------------
  for (genvar i = 0; i < `CHANNELS; i++) begin : chan
    wire cur_hit = st_reg.setup.current_ch == 3'(i);
    assign drv.bias[i] = cur_hit && st_reg.setup.current_en
                         && !st_reg.setup.measure_sel;
    assign drv.source[i] = cur_hit && st_reg.setup.write && st_reg.setup.current_en
                           && st_reg.setup.measure_sel && !st_reg.setup.switch_en;
    assign drv.sink[i] = drv.source[i];
    assign drv.low_side[i] = cur_hit && st_reg.setup.switch_en
                             && !st_reg.setup.switch_high;
    assign drv.high_side[i] = cur_hit && st_reg.setup.switch_en
                              && st_reg.setup.switch_high;
    assign drv.monitor[i] = st_reg.setup.monitor_ch == 3'(i);
  end

  assign drv.analog_output_pin_oe = st_reg.setup.analog_output_pin_en;
  assign drv.calibrate = st_reg.setup.calibrate;

  // ----------------------------------------
  // State update
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.cmp_meta = cmp_in;
    st_next.cmp_sync = st_reg.cmp_meta;
    st_next.drive = drv;
    if (frame_done) begin
      st_next.pending = is_diag;
      if (is_diag && parity_ok && rx_word[12]) begin
        st_next.setup = squib_diag_pkg::setup_type'(rx_word[12:0]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.setup <= `SETUP_RESET;
      st_reg.drive.monitor <= `MONITOR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bias_current_en = st_reg.drive.bias;
  assign measure_source_en = st_reg.drive.source;
  assign measure_sink_en = st_reg.drive.sink;
  assign low_side_test_en = st_reg.drive.low_side;
  assign high_side_test_en = st_reg.drive.high_side;
  assign monitor_select = st_reg.drive.monitor;
  assign analog_output_oe = st_reg.drive.analog_output_pin_oe;
  assign analog_output_calibrate = st_reg.drive.calibrate;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (rst);

  write_apply_a: assert property (
    frame_done && is_diag && parity_ok && rx_word[12]
    |=> st_reg.setup == $past(rx_word[12:0])
  ) else $error("write frame did not load settings");

  read_hold_a: assert property (
    frame_done && is_diag && !rx_word[12] |=> $stable(st_reg.setup)
  ) else $error("read frame changed settings");

  parity_hold_a: assert property (
    frame_done && !parity_ok |=> $stable(st_reg.setup)
  ) else $error("bad parity frame changed settings");

  other_mode_a: assert property (
    frame_done && !is_diag |=> $stable(st_reg.setup) && !st_reg.pending
  ) else $error("non-diagnostic frame touched diagnostic state");

  settle_hold_a: assert property (
    !frame_done |=> $stable(st_reg.setup)
  ) else $error("settings changed without a frame");

  reply_mode_a: assert property (
    frame_done |=> st_reg.pending == $past(is_diag)
  ) else $error("reply kind not taken from the last frame");

  reply_load_a: assert property (
    frame_start |-> miso == st_reg.pending
  ) else $error("reply loaded at frame open has the wrong mode");

  read_reply_a: assert property (
    frame_done && is_diag && !rx_word[12] |=> st_reg.pending
  ) else $error("read frame not answered");

  parity_reply_a: assert property (
    frame_done && is_diag && !parity_ok |=> st_reg.pending
  ) else $error("bad parity frame not answered");

  frame_whole_a: assert property (
    frame_done |-> port.st_reg.count == `FRAME_BITS
  ) else $error("frame taken with a wrong bit count");

  measure_gate_a: assert property (
    measure_source_en != 8'h00 |->
    $past(st_reg.setup.write && st_reg.setup.current_en
          && st_reg.setup.measure_sel && !st_reg.setup.switch_en)
    && measure_sink_en == measure_source_en
  ) else $error("measure current on outside its enable condition");

  source_route_a: assert property (
    st_reg.setup.write && st_reg.setup.current_en && st_reg.setup.measure_sel
    && !st_reg.setup.switch_en
    |=> measure_source_en == (8'h01 << $past(st_reg.setup.current_ch))
    && measure_sink_en == measure_source_en
  ) else $error("measure current not routed to selected channel");

  measure_off_a: assert property (
    !(st_reg.setup.write && st_reg.setup.current_en && st_reg.setup.measure_sel
      && !st_reg.setup.switch_en) |=> measure_source_en == 8'h00 && measure_sink_en == 8'h00
  ) else $error("measure current left on when not enabled");

  current_off_a: assert property (
    !st_reg.setup.current_en |=>
    bias_current_en == 8'h00 && measure_source_en == 8'h00
  ) else $error("diagnostic current on while disabled");

  bias_route_a: assert property (
    st_reg.setup.current_en && !st_reg.setup.measure_sel
    |=> bias_current_en == (8'h01 << $past(st_reg.setup.current_ch))
  ) else $error("bias current not routed to selected channel");

  switch_sel_a: assert property (
    st_reg.setup.switch_en |=> st_reg.setup.switch_en && $stable(st_reg.setup)
      |-> (st_reg.setup.switch_high ? high_side_test_en : low_side_test_en)
          == (8'h01 << st_reg.setup.current_ch)
  ) else $error("switch test on wrong side or channel");

  switch_off_a: assert property (
    !st_reg.setup.switch_en |=>
    low_side_test_en == 8'h00 && high_side_test_en == 8'h00
  ) else $error("switch test on while disabled");

  switch_one_a: assert property (
    $onehot0(low_side_test_en | high_side_test_en)
    && (low_side_test_en & high_side_test_en) == 8'h00
  ) else $error("switch test on several channels or both sides");

  low_route_a: assert property (
    st_reg.setup.switch_en && !st_reg.setup.switch_high
    |=> low_side_test_en == (8'h01 << $past(st_reg.setup.current_ch))
    && high_side_test_en == 8'h00
  ) else $error("low side test not on selected channel");

  single_chan_a: assert property (
    $onehot0(bias_current_en | measure_source_en) && $onehot(monitor_select)
  ) else $error("a multiplexer addresses several channels");

  monitor_sel_a: assert property (
    ##1 monitor_select == (8'h01 << $past(st_reg.setup.monitor_ch))
  ) else $error("monitor select does not follow the field");

  analog_output_pin_ctrl_a: assert property (
    ##1 analog_output_oe == $past(st_reg.setup.analog_output_pin_en)
    && analog_output_calibrate == $past(st_reg.setup.calibrate)
  ) else $error("analog output control does not follow settings");

  analog_output_pin_off_a: assert property (
    !st_reg.setup.analog_output_pin_en |=> !analog_output_oe
  ) else $error("analog output driven while disabled");

  reset_value_a: assert property (
    $past(rst) |-> st_reg.setup == `SETUP_RESET && !st_reg.pending
  ) else $error("settings not cleared by reset");

  reset_out_a: assert property (
    $past(rst) |-> monitor_select == `MONITOR_RESET && !analog_output_oe
    && !analog_output_calibrate && bias_current_en == 8'h00
    && measure_source_en == 8'h00 && low_side_test_en == 8'h00
    && high_side_test_en == 8'h00
  ) else $error("control outputs not at reset values");

  ground_bit_a: assert property (
    frame_start && st_reg.pending |-> port.st_reg.shift_out[7]
    == $past(st_reg.cmp_sync.ground_below[st_reg.setup.monitor_ch])
  ) else $error("reply bit 7 not from monitored channel");

  battery_bit_a: assert property (
    frame_start && st_reg.pending |-> port.st_reg.shift_out[13]
    == $past(st_reg.cmp_sync.battery_short[st_reg.setup.monitor_ch])
  ) else $error("reply bit 13 not from monitored channel");

  fault_bits_a: assert property (
    frame_start && st_reg.pending && $past(st_reg.cmp_sync.battery_short) == 8'h00
    && $past(st_reg.cmp_sync.overcurrent) == 8'h00
    |-> !port.st_reg.shift_out[13] && !port.st_reg.shift_out[3]
  ) else $error("fault bits set with no fault present");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  write_frame_c: cover property (
    frame_done && is_diag && parity_ok && rx_word[12]
  );

  read_frame_c: cover property (
    frame_done && is_diag && parity_ok && !rx_word[12]
  );

  bad_parity_c: cover property (
    frame_done && is_diag && !parity_ok
  );

  measure_on_c: cover property (
    measure_source_en != 8'h00 && analog_output_oe
  );

  switch_test_c: cover property (
    low_side_test_en != 8'h00 || high_side_test_en != 8'h00
  );

endmodule : squib_diagnostic_mode_decoder

// [test/host_link_model.sv]
// Purpose: Host model, link master for the diagnostic decoder
// Assumes: Link clock idles low; data set before rise, reply read while high
// Notes:   Half period of 4 clk, 160 ns per bit; clock stands still between frames

`timescale 1ns/1ps

module host_link_model (
  // Clock
  input wire logic clk,
  // Link pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // One frame, MSB first; the reply belongs to the previous frame
  task automatic send_frame(input logic [15:0] tx, output logic [15:0] rx);
    step(1);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      step(4);
      sclk = 1'b1;
      step(2);
      rx[i] = miso;
      step(2);
      sclk = 1'b0;
    end
    step(4);
    cs_n = 1'b1;
    // Released data line must not keep its last value
    mosi = ~mosi;
    step(12);
  endtask : send_frame
endmodule : host_link_model

// [test/tb_top.sv]
// Purpose: Self-checking bench of the diagnostic-mode command decoder
// Assumes: Host model drives the link; comparator levels held steady per frame
// Notes:   Every frame checks the control outputs and, after the first, the previous reply

`timescale 1ns/1ps

module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk, cs_n, mosi, miso;
  logic [7:0] ground_below = 8'h00;
  logic [7:0] battery_short = 8'h00;
  logic [7:0] overcurrent = 8'h00;
  logic [7:0] switch_fault = 8'h00;
  logic [7:0] bias_current_en, measure_source_en, measure_sink_en;
  logic [7:0] low_side_test_en, high_side_test_en, monitor_select;
  logic analog_output_oe, analog_output_calibrate;
  logic [49:0] ctrl_seen;
  int failures = 0;
  int checks_done = 0;
  logic [12:0] cur_set = 13'h0000;
  logic prev_diag = 1'b0;
  logic have_exp = 1'b0;

  always #10 clk = ~clk;

  assign ctrl_seen = {bias_current_en, measure_source_en, measure_sink_en, low_side_test_en,
    high_side_test_en, monitor_select, analog_output_oe, analog_output_calibrate};

  squib_diagnostic_mode_decoder DUT (.clk, .rst, .sclk, .cs_n, .mosi, .miso,
    .ground_below, .battery_short, .overcurrent, .switch_fault, .bias_current_en,
    .measure_source_en, .measure_sink_en, .low_side_test_en, .high_side_test_en,
    .monitor_select, .analog_output_oe, .analog_output_calibrate);

  host_link_model host (.clk, .sclk, .cs_n, .mosi, .miso);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] cmd(input logic [1:0] mode, input logic [12:0] s);
    logic [15:0] w;
    w = {mode, 1'b0, s};
    w[13] = ~(^w);
    return w;
  endfunction : cmd

  function automatic logic [49:0] ctrl_of(input logic [12:0] s);
    logic [7:0] c, m;
    c = 8'h01 << s[2:0];
    m = 8'h01 << s[6:4];
    return {(s[9] & !s[8]) ? c : 8'h00,
      (s[12] & s[9] & s[8] & !s[11]) ? {c, c} : 16'h0000,
      (s[11] & !s[10]) ? c : 8'h00, (s[11] & s[10]) ? c : 8'h00, m, s[7], s[3]};
  endfunction : ctrl_of

  function automatic logic [15:0] reply_of(input logic [12:0] s);
    return {2'h2, battery_short[s[6:4]], switch_fault[s[2:0]], s[11:8],
      ground_below[s[6:4]], s[6:4], overcurrent[s[6:4]], s[2:0]};
  endfunction : reply_of

  task automatic frame(input logic [15:0] w);
    logic [15:0] rx;
    logic [15:0] exp;
    logic [49:0] e;
    host.send_frame(w, rx);
    exp = prev_diag ? reply_of(cur_set) : 16'h0000;
    if (have_exp) check("reply", {48'h0, rx}, {48'h0, exp});
    have_exp = 1'b1;
    prev_diag = (w[15:14] == 2'h2);
    if (prev_diag && ^w && w[12]) cur_set = w[12:0];
    e = ctrl_of(cur_set);
    check("currents", 64'(ctrl_seen[49:26]), 64'(e[49:26]));
    check("switches", 64'(ctrl_seen[25:0]), 64'(e[25:0]));
  endtask : frame

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset();
    check("reset controls", {14'h0, ctrl_seen}, {14'h0, 40'h0, 8'h01, 2'h0});
    check("reset miso", {63'h0, miso}, 64'h0);
  endtask : test_reset

  task automatic test_writes();
    logic [12:0] tbl [5] = '{13'h1210, 13'h13d7, 13'h1f7b, 13'h19a5, 13'h1406};
    foreach (tbl[i]) begin
      frame(cmd(2'h2, tbl[i]));
      // Read with every other bit set must leave settings alone
      frame(cmd(2'h2, 13'h0fff));
    end
  endtask : test_writes

  task automatic test_parity();
    frame(cmd(2'h2, 13'h1fff) ^ 16'h2000);
    frame(cmd(2'h2, 13'h0000));
  endtask : test_parity

  task automatic test_modes();
    logic [1:0] modes [3] = '{2'h0, 2'h1, 2'h3};
    foreach (modes[i]) frame(cmd(modes[i], 13'h1fff));
    frame(cmd(2'h2, 13'h0000));
  endtask : test_modes

  task automatic test_loops();
    ground_below = 8'hfd;
    battery_short = 8'h10;
    overcurrent = 8'h40;
    switch_fault = 8'h08;
    // Bias channel 0, step the monitor over the others
    for (int m = 1; m < 8; m++) frame(cmd(2'h2, 13'h1200 | {6'h00, 3'(m), 4'h0}));
    // Only this device drives the converter input
    frame(cmd(2'h2, 13'h1883));
    frame(cmd(2'h2, 13'h0000));
  endtask : test_loops

  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    test_reset();
    test_writes();
    test_parity();
    test_modes();
    test_loops();
    test_done();
  end

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule : tb_top
